// [hdl/responder_pkg.sv]
// Purpose: Shared constants for the multi-drop packet responder.
// Assumes: Byte count field is two bytes, opcode field is two bytes.
// Notes:   Response codes listed here are returned by the unit logic; the responder also sets RESP_TOO_LONG itself.
`default_nettype none

package responder_pkg;

    // Framing
    localparam logic [7:0]  FRAME_SYNC_CHAR   = 8'h16;
    localparam logic [7:0]  BROADCAST_ID      = 8'h00;
    localparam logic [7:0]  RESERVED_TYPE_LO  = 8'h18;
    localparam logic [7:0]  RESERVED_TYPE_HI  = 8'h1f;
    localparam int unsigned MAX_COUNT_FIELD   = 65535;

    // Response frame byte positions
    localparam logic [3:0]  RB_SYNC           = 4'h0;
    localparam logic [3:0]  RB_COUNT_HI       = 4'h1;
    localparam logic [3:0]  RB_COUNT_LO       = 4'h2;
    localparam logic [3:0]  RB_SENDER         = 4'h3;
    localparam logic [3:0]  RB_TARGET         = 4'h4;
    localparam logic [3:0]  RB_SEQ            = 4'h5;
    localparam logic [3:0]  RB_OP_HI          = 4'h6;
    localparam logic [3:0]  RB_OP_LO          = 4'h7;
    localparam logic [3:0]  RB_CHECKSUM       = 4'h8;
    localparam logic [7:0]  RESP_DATA_COUNT   = 8'h00;

    // Global response codes
    localparam logic [15:0] RESP_GOOD         = 16'h0000;
    localparam logic [15:0] RESP_BAD_PARAM    = 16'h00ff;
    localparam logic [15:0] RESP_BAD_OPCODE   = 16'h00fe;
    localparam logic [15:0] RESP_BAD_CHECKSUM = 16'h00fd;
    localparam logic [15:0] RESP_LOCAL_MODE   = 16'h00fc;
    localparam logic [15:0] RESP_AUTO_MODE    = 16'h00fb;
    localparam logic [15:0] RESP_BAD_DEST     = 16'h00fa;
    localparam logic [15:0] RESP_UNABLE       = 16'h00f9;
    localparam logic [15:0] RESP_TOO_LONG     = 16'h00f8;

    // Unit-specific refusal codes
    localparam logic [15:0] UNIT_CONTROL_MODE = 16'h0203;
    localparam logic [15:0] UNIT_BAD_PARAM    = 16'h0204;
    localparam logic [15:0] UNIT_RANGE        = 16'h0220;
    localparam logic [15:0] UNIT_RANGE_LOW    = 16'h0221;
    localparam logic [15:0] UNIT_RANGE_HIGH   = 16'h0222;

    typedef enum logic [3:0] {
        S_WAIT_SYNC = 4'b0000,
        S_COUNT_HI  = 4'b0001,
        S_COUNT_LO  = 4'b0010,
        S_SENDER    = 4'b0011,
        S_TARGET    = 4'b0100,
        S_SEQ       = 4'b0101,
        S_OP_HI     = 4'b0110,
        S_OP_LO     = 4'b0111,
        S_DATA      = 4'b1000,
        S_CHECKSUM  = 4'b1001,
        S_DECIDE    = 4'b1010,
        S_EXEC      = 4'b1011,
        S_SEND      = 4'b1100
    } rx_state_t;

endpackage : responder_pkg

`default_nettype wire

// [hdl/seq_track_if.sv]
// Purpose: Carrier between the frame engine and the sequence tracker.
// Assumes: Lookup and write share the sender and sequence fields.
// Notes:   Lookup answer is combinational.
`timescale 1ns/1ps
`default_nettype none

interface seq_track_if;
    logic [7:0]  look_sender;
    logic [7:0]  look_seq;
    logic        hit;
    logic [15:0] hit_code;
    logic        wr;
    logic [15:0] wr_code;

    modport client (
        output look_sender,
        output look_seq,
        output wr,
        output wr_code,
        input  hit,
        input  hit_code
    );

    modport tracker (
        input  look_sender,
        input  look_seq,
        input  wr,
        input  wr_code,
        output hit,
        output hit_code
    );
endinterface : seq_track_if

`default_nettype wire

// [hdl/seq_tracker.sv]
// Purpose: Remembers the last sequence number and answer per sender.
// Assumes: One entry for each of the 256 sender addresses.
// Notes:   Only the seen flags are reset; stored values need no reset.
`timescale 1ns/1ps
`default_nettype none

module seq_tracker (
    input  wire logic    clk,
    input  wire logic    rst_n,
    seq_track_if.tracker trk
);

    logic [255:0] seen;
    logic [7:0]   last_seq  [256];
    logic [15:0]  last_code [256];

    // Repeat of the previous number from this sender
    assign trk.hit      = seen[trk.look_sender]
                          && (last_seq[trk.look_sender] == trk.look_seq);
    assign trk.hit_code = last_code[trk.look_sender];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            seen <= '0;
        end else if (trk.wr) begin
            seen[trk.look_sender] <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (trk.wr) begin
            last_seq[trk.look_sender]  <= trk.look_seq;
            last_code[trk.look_sender] <= trk.wr_code;
        end
    end

endmodule : seq_tracker

`default_nettype wire

// [hdl/multidrop_packet_responder.sv]
// Purpose: Receives checksummed bus frames and returns response frames.
// Assumes: Byte stream comes from a receiver on the same clock.
// Notes:   Payload bytes are provisional until exec_valid is seen.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Idle until sync, then collect frame
// - Bad checksum drops frame, back to idle
// - Opcode is command class or query code
// - Repeat number: skip execution, still answer
// - Unseen resend is executed as new
// - Eight-bit sequence number wraps to zero
// - Answer carries the received sequence number
// - Answer swaps addresses, code in opcode
// - Valid message answered with code zero
// - Parameter, opcode, checksum error codes
// - Local, auto mode and destination codes
// - Unable and too-long packet codes
// - Unit-specific refusals use 02xx codes
// - Accept own type override identifier
// - Accept broadcast zero, never answer
// - Override values 24 to 31 never match
// - Frames open with sync character
// - Checksum is byte sum after sync
// - Fixed order of frame fields
// - Opcode field is two bytes
module multidrop_packet_responder #(
    parameter int unsigned MAX_DATA_LEN = 255
) (
    input  wire logic        ref_clk,
    input  wire logic        resetn,
    input  wire logic [7:0]  own_address,
    input  wire logic [7:0]  type_override_id,
    input  wire logic [7:0]  rx_data,
    input  wire logic        rx_valid,
    output logic             rx_ready,
    output logic [7:0]       payload_data,
    output logic             payload_valid,
    output logic             exec_valid,
    output logic [15:0]      exec_opcode,
    output logic [7:0]       exec_sender,
    output logic [7:0]       exec_seq,
    output logic             exec_broadcast,
    input  wire logic [15:0] result_code,
    input  wire logic        result_valid,
    output logic [7:0]       tx_data,
    output logic             tx_valid,
    input  wire logic        tx_ready,
    output logic             tx_oe_n,
    output logic             checksum_fault
);

    if (MAX_DATA_LEN > responder_pkg::MAX_COUNT_FIELD) begin : g_len_check
        $error("MAX_DATA_LEN does not fit the byte count field");
    end

    // Byte of the response frame at a given position
    function automatic logic [7:0] resp_byte(
        input logic [3:0]  idx,
        input logic [7:0]  from_addr,
        input logic [7:0]  to_addr,
        input logic [7:0]  seq,
        input logic [15:0] code
    );
        logic [7:0] sum;
        sum = from_addr + to_addr + seq + code[15:8] + code[7:0];
        unique case (idx)
            responder_pkg::RB_SYNC:     resp_byte = responder_pkg::FRAME_SYNC_CHAR;
            responder_pkg::RB_COUNT_HI: resp_byte = responder_pkg::RESP_DATA_COUNT;
            responder_pkg::RB_COUNT_LO: resp_byte = responder_pkg::RESP_DATA_COUNT;
            responder_pkg::RB_SENDER:   resp_byte = from_addr;
            responder_pkg::RB_TARGET:   resp_byte = to_addr;
            responder_pkg::RB_SEQ:      resp_byte = seq;
            responder_pkg::RB_OP_HI:    resp_byte = code[15:8];
            responder_pkg::RB_OP_LO:    resp_byte = code[7:0];
            default:                    resp_byte = sum;
        endcase
    endfunction : resp_byte

    // Reset release and strap synchronisers
    logic [1:0]  rst_sync;
    logic        rst_n;
    logic [7:0]  addr_meta;
    logic [7:0]  addr_q;
    logic [7:0]  type_meta;
    logic [7:0]  type_q;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rst_sync <= 2'b00;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            addr_meta <= 8'h00;
            addr_q    <= 8'h00;
            type_meta <= 8'h00;
            type_q    <= 8'h00;
        end else begin
            addr_meta <= own_address;
            addr_q    <= addr_meta;
            type_meta <= type_override_id;
            type_q    <= type_meta;
        end
    end

    responder_pkg::rx_state_t state;
    responder_pkg::rx_state_t next_state;

    logic [7:0]  count_hi;
    logic [15:0] data_left;
    logic [7:0]  sender;
    logic [7:0]  target;
    logic [7:0]  seq;
    logic [7:0]  op_hi;
    logic [7:0]  sum;
    logic        too_long;
    logic [15:0] resp_code;
    logic [3:0]  tx_idx;

    seq_track_if trk ();

    seq_tracker u_tracker (
        .clk   (ref_clk),
        .rst_n (rst_n),
        .trk   (trk)
    );

    // Selection and decode
    wire        take      = rx_valid && rx_ready;
    wire [15:0] count_now = {count_hi, rx_data};
    wire        sum_ok    = (rx_data == sum);
    wire        is_bcast  = (target == responder_pkg::BROADCAST_ID);
    wire        type_resv = (type_q >= responder_pkg::RESERVED_TYPE_LO)
                            && (type_q <= responder_pkg::RESERVED_TYPE_HI);
    wire        type_ok   = !type_resv
                            && (type_q != responder_pkg::BROADCAST_ID);
    wire        is_ovr    = type_ok && (target == type_q);
    wire        addressed = (target == addr_q) || is_ovr || is_bcast;
    wire        tx_take   = tx_valid && tx_ready;
    wire        tx_last   = (tx_idx == responder_pkg::RB_CHECKSUM);
    wire        dec_long  = (state == responder_pkg::S_DECIDE) && addressed
                            && !trk.hit && too_long;
    wire        exec_done = (state == responder_pkg::S_EXEC) && result_valid;
    wire [3:0]  tx_next   = tx_idx + 4'd1;

    assign rx_ready        = (state <= responder_pkg::S_CHECKSUM);
    assign tx_valid        = (state == responder_pkg::S_SEND);
    assign tx_oe_n         = !(state == responder_pkg::S_SEND);
    assign trk.look_sender = sender;
    assign trk.look_seq    = seq;
    assign trk.wr          = dec_long || exec_done;
    assign trk.wr_code     = dec_long ? responder_pkg::RESP_TOO_LONG
                                      : result_code;

    always_comb begin
        next_state = state;
        unique case (state)
            responder_pkg::S_WAIT_SYNC: begin
                if (take && rx_data == responder_pkg::FRAME_SYNC_CHAR) begin
                    next_state = responder_pkg::S_COUNT_HI;
                end
            end
            responder_pkg::S_COUNT_HI: if (take) next_state = responder_pkg::S_COUNT_LO;
            responder_pkg::S_COUNT_LO: if (take) next_state = responder_pkg::S_SENDER;
            responder_pkg::S_SENDER:   if (take) next_state = responder_pkg::S_TARGET;
            responder_pkg::S_TARGET:   if (take) next_state = responder_pkg::S_SEQ;
            responder_pkg::S_SEQ:      if (take) next_state = responder_pkg::S_OP_HI;
            responder_pkg::S_OP_HI:    if (take) next_state = responder_pkg::S_OP_LO;
            responder_pkg::S_OP_LO: begin
                if (take) begin
                    next_state = (data_left == 16'h0000)
                                 ? responder_pkg::S_CHECKSUM
                                 : responder_pkg::S_DATA;
                end
            end
            responder_pkg::S_DATA: begin
                if (take && data_left == 16'h0001) begin
                    next_state = responder_pkg::S_CHECKSUM;
                end
            end
            responder_pkg::S_CHECKSUM: begin
                if (take) begin
                    next_state = sum_ok ? responder_pkg::S_DECIDE
                                        : responder_pkg::S_WAIT_SYNC;
                end
            end
            responder_pkg::S_DECIDE: begin
                if (!addressed) begin
                    next_state = responder_pkg::S_WAIT_SYNC;
                end else if (trk.hit || too_long) begin
                    next_state = is_bcast ? responder_pkg::S_WAIT_SYNC
                                          : responder_pkg::S_SEND;
                end else begin
                    next_state = responder_pkg::S_EXEC;
                end
            end
            responder_pkg::S_EXEC: begin
                if (result_valid) begin
                    next_state = is_bcast ? responder_pkg::S_WAIT_SYNC
                                          : responder_pkg::S_SEND;
                end
            end
            responder_pkg::S_SEND: begin
                if (tx_take && tx_last) begin
                    next_state = responder_pkg::S_WAIT_SYNC;
                end
            end
            default: next_state = responder_pkg::S_WAIT_SYNC;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= responder_pkg::S_WAIT_SYNC;
        end else begin
            state <= next_state;
        end
    end

    // Header capture and running checksum
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            count_hi  <= 8'h00;
            data_left <= 16'h0000;
            sender    <= 8'h00;
            target    <= 8'h00;
            seq       <= 8'h00;
            op_hi     <= 8'h00;
            sum       <= 8'h00;
            too_long  <= 1'b0;
        end else if (take) begin
            sum <= (state == responder_pkg::S_WAIT_SYNC) ? 8'h00
                                                         : sum + rx_data;
            unique case (state)
                responder_pkg::S_COUNT_HI: count_hi <= rx_data;
                responder_pkg::S_COUNT_LO: begin
                    data_left <= count_now;
                    too_long  <= count_now > 16'(MAX_DATA_LEN);
                end
                responder_pkg::S_SENDER:   sender <= rx_data;
                responder_pkg::S_TARGET:   target <= rx_data;
                responder_pkg::S_SEQ:      seq    <= rx_data;
                responder_pkg::S_OP_HI:    op_hi  <= rx_data;
                responder_pkg::S_DATA:     data_left <= data_left - 16'd1;
                default: ;
            endcase
        end
    end

    // Payload stream, execution strobe and fault pulse
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            payload_data   <= 8'h00;
            payload_valid  <= 1'b0;
            exec_valid     <= 1'b0;
            exec_opcode    <= 16'h0000;
            exec_sender    <= 8'h00;
            exec_seq       <= 8'h00;
            exec_broadcast <= 1'b0;
            checksum_fault <= 1'b0;
        end else begin
            payload_valid  <= take && (state == responder_pkg::S_DATA)
                              && !too_long;
            checksum_fault <= take && (state == responder_pkg::S_CHECKSUM)
                              && !sum_ok;
            exec_valid     <= (state == responder_pkg::S_DECIDE)
                              && (next_state == responder_pkg::S_EXEC);
            if (take && state == responder_pkg::S_DATA) begin
                payload_data <= rx_data;
            end
            if (take && state == responder_pkg::S_OP_LO) begin
                exec_opcode <= {op_hi, rx_data};
            end
            if (state == responder_pkg::S_DECIDE) begin
                exec_sender    <= sender;
                exec_seq       <= seq;
                exec_broadcast <= is_bcast;
            end
        end
    end

    // Response code selection and frame transmit
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            resp_code <= responder_pkg::RESP_GOOD;
            tx_idx    <= responder_pkg::RB_SYNC;
            tx_data   <= 8'h00;
        end else begin
            if (state == responder_pkg::S_DECIDE) begin
                resp_code <= trk.hit ? trk.hit_code
                                     : responder_pkg::RESP_TOO_LONG;
            end else if (exec_done) begin
                resp_code <= result_code;
            end
            if (state != responder_pkg::S_SEND
                && next_state == responder_pkg::S_SEND) begin
                tx_idx  <= responder_pkg::RB_SYNC;
                tx_data <= responder_pkg::FRAME_SYNC_CHAR;
            end else if (tx_take && !tx_last) begin
                tx_idx  <= tx_next;
                tx_data <= resp_byte(tx_next, target, sender, seq,
                                     resp_code);
            end
        end
    end

endmodule : multidrop_packet_responder

`default_nettype wire

// [testbench/responder_sva.sv]
// Purpose: Port-level checks for the packet responder.
// Assumes: Bound to every responder instance.
// Notes:   A small counter tracks bytes taken per response frame.
`timescale 1ns/1ps
`default_nettype none

module responder_sva #(
    parameter int unsigned MAX_DATA_LEN = 255
) (
    input wire logic       ref_clk,
    input wire logic       resetn,
    input wire logic       rx_ready,
    input wire logic       exec_valid,
    input wire logic       exec_broadcast,
    input wire logic       result_valid,
    input wire logic [7:0] tx_data,
    input wire logic       tx_valid,
    input wire logic       tx_ready,
    input wire logic       tx_oe_n,
    input wire logic       checksum_fault
);
    logic [3:0] sent;
    logic [3:0] next_sent;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    assign next_sent = tx_valid ? sent + {3'h0, tx_ready} : 4'h0;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            sent <= 4'h0;
        end else begin
            sent <= next_sent;
        end
    end

    property p_oe; tx_oe_n == !tx_valid; endproperty
    a_oe: assert property (p_oe) else $error("line enable wrong");
    property p_first; $rose(tx_valid) |-> tx_data == 8'h16; endproperty
    a_first: assert property (p_first) else $error("no sync");
    property p_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_data);
    endproperty
    a_hold: assert property (p_hold) else $error("byte dropped");
    property p_len; $fell(tx_valid) |-> sent == 4'h9; endproperty
    a_len: assert property (p_len) else $error("frame length");
    property p_busy; exec_valid || tx_valid |-> !rx_ready; endproperty
    a_busy: assert property (p_busy) else $error("rx open");
    property p_pulse; exec_valid |=> !exec_valid; endproperty
    a_pulse: assert property (p_pulse) else $error("exec twice");
    property p_answer;
        exec_valid && !exec_broadcast ##1 result_valid |=> $rose(tx_valid);
    endproperty
    a_answer: assert property (p_answer) else $error("no answer");
    property p_bcast; exec_valid && exec_broadcast |-> !tx_valid [*8];
    endproperty
    a_bcast: assert property (p_bcast) else $error("bcast answered");
    property p_fault;
        checksum_fault |=> (!exec_valid && !tx_valid && !checksum_fault) [*3];
    endproperty
    a_fault: assert property (p_fault) else $error("bad frame used");

    c_bcast: cover property (exec_valid && exec_broadcast);
    c_fault: cover property (checksum_fault);
    c_resp: cover property ($fell(tx_valid));
endmodule : responder_sva

bind multidrop_packet_responder responder_sva #(
    .MAX_DATA_LEN(MAX_DATA_LEN)
) responder_sva_inst (
    .ref_clk(ref_clk), .resetn(resetn), .rx_ready(rx_ready),
    .exec_valid(exec_valid), .exec_broadcast(exec_broadcast),
    .result_valid(result_valid), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_oe_n(tx_oe_n), .checksum_fault(checksum_fault)
);

`default_nettype wire

// [testbench/host_model.sv]
// Purpose: Host computer on the shared bus: sends frames, takes answers.
// Assumes: Byte stream already deframed, same clock as the responder.
// Notes:   Idle receive line shows the inverse of the last byte.
`timescale 1ns/1ps
`default_nettype none

module host_model (
    input  wire logic       ref_clk,
    output logic [7:0]      rx_data,
    output logic            rx_valid,
    input  wire logic       rx_ready,
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_valid,
    output logic            tx_ready
);
    logic [7:0] resp [9];

    initial begin
        rx_data  = 8'h00;
        rx_valid = 1'b0;
        tx_ready = 1'b1;
    end

    task automatic put(input logic [7:0] b);
        rx_data  <= b;
        rx_valid <= 1'b1;
        do @(posedge ref_clk); while (rx_ready !== 1'b1);
    endtask : put

    task automatic send_frame(input logic [7:0] snd, tgt, sq,
                              input logic [15:0] op, cnt, input logic bad);
        logic [7:0] h [7];
        logic [7:0] sum;
        logic [7:0] d;
        h = '{cnt[15:8], cnt[7:0], snd, tgt, sq, op[15:8], op[7:0]};
        sum = 8'h00;
        @(posedge ref_clk);
        put(8'h16);
        for (int i = 0; i < 7; i++) begin
            put(h[i]);
            sum = sum + h[i];
        end
        for (int i = 0; i < cnt; i++) begin
            d = 8'hdf + 8'(i) * 8'h1f;
            put(d);
            sum = sum + d;
        end
        d = bad ? ~sum : sum;
        put(d);
        rx_valid <= 1'b0;
        rx_data  <= ~d;
    endtask : send_frame

    // Bounded wait doubles as the response timeout
    task automatic get_resp(input int slow, output int n);
        n = 0;
        for (int w = 0; w < 60 && n < 9; w++) begin
            @(posedge ref_clk);
            if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
                resp[n] = tx_data;
                n++;
            end
            tx_ready <= (slow == 0) || (w % 2 == 1);
        end
    endtask : get_resp
endmodule : host_model

`default_nettype wire

// [testbench/tb.sv]
// Purpose: Self-checking bench for the packet responder.
// Assumes: Host model sends frames, bench plays the unit logic.
// Notes:   Opcode of each frame is its sequence number.
`timescale 1ns/1ps
`default_nettype none

module tb;
    localparam int unsigned MAX_LEN = 4;
    // Arbitrary override identifier for this unit
    localparam logic [7:0]  OVR_ID = 8'h0b;
    logic        ref_clk, resetn, rx_valid, rx_ready, payload_valid;
    logic        exec_valid, exec_broadcast, result_valid, tx_valid;
    logic        tx_ready, tx_oe_n, checksum_fault;
    logic [7:0]  own_address, type_override_id, rx_data, payload_data;
    logic [7:0]  exec_sender, exec_seq, tx_data;
    logic [15:0] exec_opcode, result_code, unit_code;
    int          err_count, comparisons, execs, faults;
    logic [7:0]  pay_q [$];

    multidrop_packet_responder #(
        .MAX_DATA_LEN(MAX_LEN)
    ) multidrop_packet_responder_inst (
        .ref_clk(ref_clk), .resetn(resetn), .own_address(own_address),
        .type_override_id(type_override_id), .rx_data(rx_data),
        .rx_valid(rx_valid), .rx_ready(rx_ready),
        .payload_data(payload_data), .payload_valid(payload_valid),
        .exec_valid(exec_valid), .exec_opcode(exec_opcode),
        .exec_sender(exec_sender), .exec_seq(exec_seq),
        .exec_broadcast(exec_broadcast), .result_code(result_code),
        .result_valid(result_valid), .tx_data(tx_data),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_oe_n(tx_oe_n),
        .checksum_fault(checksum_fault)
    );

    host_model host_model_inst (
        .ref_clk(ref_clk), .rx_data(rx_data), .rx_valid(rx_valid),
        .rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid),
        .tx_ready(tx_ready)
    );

    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    // Unit logic answers the cycle after each execute pulse
    always @(posedge ref_clk) begin
        result_valid <= exec_valid;
        result_code  <= unit_code;
        if (exec_valid === 1'b1) execs++;
        if (checksum_fault === 1'b1) faults++;
        if (payload_valid === 1'b1) pay_q.push_back(payload_data);
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
        end
    endtask : chk

    task automatic fr(input logic [7:0] snd, tgt, sq,
                      input logic [15:0] cnt, code,
                      input int bad, slow, ex, rs);
        int         n0;
        int         n;
        logic [7:0] e [9];
        n0 = execs;
        unit_code = code;
        host_model_inst.send_frame(snd, tgt, sq, {8'h00, sq}, cnt, bad[0]);
        host_model_inst.get_resp(slow, n);
        chk(16'(execs - n0), 16'(ex));
        chk(16'(n), 16'(rs));
        if (ex == 1) begin
            chk(exec_opcode, {8'h00, sq});
            chk({exec_sender, exec_seq}, {snd, sq});
            chk({15'h0000, exec_broadcast}, {15'h0000, (tgt == 8'h00)});
        end
        e = '{8'h16, 8'h00, 8'h00, tgt, snd, sq, code[15:8], code[7:0],
              tgt + snd + sq + code[15:8] + code[7:0]};
        for (int i = 0; i < rs; i++) begin
            chk({8'h00, host_model_inst.resp[i]}, {8'h00, e[i]});
        end
    endtask : fr

    task automatic t_basic();
        @(posedge ref_clk);
        host_model_inst.put(8'h55);
        fr(8'hf0, 8'h2a, 8'h09, 16'h0002, 16'h0000, 0, 0, 1, 9);
        chk({pay_q[0], pay_q[1]}, 16'hdffe);
    endtask : t_basic

    task automatic t_codes();
        logic [15:0] codes [12];
        logic [7:0]  sq;
        codes = '{16'h0000, 16'h00ff, 16'h00fe, 16'h00fd, 16'h00fc, 16'h00fb,
                  16'h00fa, 16'h00f9, 16'h00f8, 16'h0203, 16'h0204, 16'h0220};
        sq = 8'hfe;
        for (int i = 0; i < 12; i++) begin
            fr(8'hf1, 8'h2a, sq, 16'h0000, codes[i], 0, i % 2, 1, 9);
            sq = sq + 8'h01;
        end
    endtask : t_codes

    task automatic t_dup();
        fr(8'hf1, 8'h2a, 8'h09, 16'h0000, 16'h0220, 0, 1, 0, 9);
    endtask : t_dup

    task automatic t_bad();
        int f0;
        f0 = faults;
        fr(8'hf3, 8'h2a, 8'h05, 16'h0001, 16'h0000, 1, 0, 0, 0);
        chk(16'(faults - f0), 16'h0001);
        fr(8'hf3, 8'h2a, 8'h05, 16'h0001, 16'h0204, 0, 0, 1, 9);
    endtask : t_bad

    task automatic t_bcast();
        fr(8'hf4, 8'h00, 8'h01, 16'h0000, 16'h0000, 0, 0, 1, 0);
        chk({15'h0000, exec_broadcast}, 16'h0001);
    endtask : t_bcast

    task automatic t_override();
        type_override_id <= OVR_ID;
        repeat (4) @(posedge ref_clk);
        fr(8'hf5, OVR_ID, 8'h01, 16'h0000, 16'h0000, 0, 1, 1, 9);
        type_override_id <= 8'h18;
        repeat (4) @(posedge ref_clk);
        fr(8'hf5, 8'h18, 8'h02, 16'h0000, 16'h0000, 0, 0, 0, 0);
        fr(8'hf5, 8'h33, 8'h03, 16'h0000, 16'h0000, 0, 0, 0, 0);
    endtask : t_override

    task automatic t_long();
        int p0;
        p0 = pay_q.size();
        fr(8'hf6, 8'h2a, 8'h01, 16'h0005, 16'h00f8, 0, 1, 0, 9);
        chk(16'(pay_q.size() - p0), 16'h0000);
        fr(8'hf6, 8'h2a, 8'h02, 16'h0004, 16'h0000, 0, 0, 1, 9);
    endtask : t_long

    task automatic wrap_up();
        $display("comparisons %0d, mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : wrap_up

    initial begin
        #60000;
        err_count++;
        wrap_up();
    end

    initial begin
        resetn = 1'b0;
        own_address = 8'h2a;
        type_override_id = 8'h00;
        unit_code = 16'h0000;
        repeat (4) @(posedge ref_clk);
        resetn <= 1'b1;
        repeat (8) @(posedge ref_clk);
        t_basic();
        t_codes();
        t_dup();
        t_bad();
        t_bcast();
        t_override();
        t_long();
        wrap_up();
    end
endmodule : tb

`default_nettype wire
